// ===== logic/ctf_regs.vh
// Register map, field positions, reset values and timing constants for the CAN fail-safe control
`ifndef CTF_REGS_VH
`define CTF_REGS_VH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define CTF_CTRL_OFF      12'h000
`define CTF_STATUS_OFF    12'h004
`define CTF_TXTO_OFF      12'h008
`define CTF_BUSTO_OFF     12'h00C
`define CTF_WAKEF_OFF     12'h010
`define CTF_STBN_OFF      12'h014
// ****************************************************************
// Field positions
// ****************************************************************
`define CTF_CTRL_SW_STB     0
`define CTF_CTRL_SW_OVR     1
`define CTF_ST_STANDBY      0
`define CTF_ST_TXTO         1
`define CTF_ST_BUSTO        2
`define CTF_ST_UV1          3
`define CTF_ST_UV2          4
`define CTF_ST_OT           5
`define CTF_ST_DRV_EN       6
`define CTF_ST_RX           7
`define CTF_ST_TRANS        8
// ****************************************************************
// Reset values
// ****************************************************************
`define CTF_CTRL_RST      32'h0000_0001
// ****************************************************************
// Timing: figures as printed, then cycles at 250 MHz (4 ns)
// ****************************************************************
`define CTF_CLK_PS          4000
`define CTF_DOM_TO_US       3000
`define CTF_WAKE_FLT_NS     1000
`define CTF_STB_NORM_NS     34000
`define CTF_DOM_TO_CYC      ((`CTF_DOM_TO_US * 1000) / (`CTF_CLK_PS / 1000))
`define CTF_WAKE_FLT_CYC    ((`CTF_WAKE_FLT_NS * 1000) / `CTF_CLK_PS)
`define CTF_STB_NORM_CYC    ((`CTF_STB_NORM_NS * 1000) / `CTF_CLK_PS)
`endif

// ===== logic/ctf_failsafe_ctrl.v
// Mode selection and fail-safe timeouts of a high-speed CAN transceiver, APB register slave
`timescale 1ns/1ps
`include "ctf_regs.vh"

// Notes on behaviour
// R01: Transmit-dominant timer starts when transmit data goes low.
// R02: Transmit low beyond the timeout disables the bus driver.
// R03: Transmit-dominant timer clears when transmit data returns high.
// R04: Controller must not send below 25 kbps or the timeout trips.
// R05: In standby, bus-dominant timer starts on recessive-to-dominant.
// R06: Bus dominant beyond the timeout forces receive output high.
// R07: Bus-dominant timer clears when the bus goes recessive.
// R08: Floating transmit input reads high, keeping transmitter recessive.
// R09: Floating standby select reads high, entering standby.
// R10: Controller should hold transmit and standby select high in standby.
// R11: First undervoltage forces standby and ignores standby select.
// R12: Second undervoltage switches off with zero bus load.
// R13: Overtemperature disables drivers, bus recessive regardless of transmit.
// R14: Under overtemperature, receive output keeps following the bus.
// R15: Drivers restored once overtemperature clears.
// R16: Standby receive output low signals wake-up, high otherwise.
// R17: Standby select low means normal mode, high means standby.
// R18: Both dominant timeouts lie between 0.8 ms and 8 ms, 3 ms typical.
// R19: Standby bus states reach receive output only after the wake filter.
// R20: Standby to normal completes 20 to 55 us after select goes low.
// R21: All durations come from counting the clock timebase.
module ctf_failsafe_ctrl #(
   parameter DOM_TO_CYC   = `CTF_DOM_TO_CYC,
   parameter WAKE_FLT_CYC = `CTF_WAKE_FLT_CYC,
   parameter STB_NORM_CYC = `CTF_STB_NORM_CYC,
   parameter CW           = 24
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        txd_in,
   input  wire        txd_in_valid,
   input  wire        stb_in,
   input  wire        stb_in_valid,
   input  wire        bus_dominant,
   input  wire        uv1_flag,
   input  wire        uv2_flag,
   input  wire        ot_flag,
   output reg         drv_dominant,
   output reg         drv_enable,
   output reg         split_enable,
   output reg         bus_bias_gnd,
   output reg         rxd_out,
   output reg         standby
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Level and driven flag synchronised apart; pull-up applied after
   reg [7:0] sync1;
   reg [7:0] sync2;

   // Undriven pin reads as its pull-up level
   function pin_level;
      input v;
      input ok;
      begin
         pin_level = ok ? v : 1'b1;
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 8'h05;
         sync2 <= 8'h05;
      end else begin
         sync1 <= {ot_flag, uv2_flag, uv1_flag, bus_dominant,
                   stb_in_valid, stb_in, txd_in_valid, txd_in};
         sync2 <= sync1;
      end
   end

   wire txd = pin_level(sync2[0], sync2[1]);  // R08
   wire stb = pin_level(sync2[2], sync2[3]);  // R09
   wire bus = sync2[4];
   wire uv1 = sync2[5];
   wire uv2 = sync2[6];
   wire ot  = sync2[7];

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg        sw_stb;
   reg        sw_ovr;
   reg [CW-1:0] tx_to_lim;
   reg [CW-1:0] bus_to_lim;
   reg [CW-1:0] wake_lim;
   reg [CW-1:0] stbn_lim;

   function [CW-1:0] inc_sat;
      input [CW-1:0] v;
      begin
         inc_sat = (&v) ? v : v + {{(CW-1){1'b0}}, 1'b1};
      end
   endfunction

   function [31:0] zext;
      input [CW-1:0] v;
      begin
         zext = {{(32-CW){1'b0}}, v};
      end
   endfunction

   // ****************************************************************
   // Mode state machine
   // ****************************************************************
   localparam [1:0] ST_STBY  = 2'd0;
   localparam [1:0] ST_TRANS = 2'd1;
   localparam [1:0] ST_NORM  = 2'd2;
   localparam [1:0] ST_OFF   = 2'd3;

   reg  [1:0]    mode;
   reg  [1:0]    next_mode;
   reg  [CW-1:0] trans_cnt;
   // Software override lets the standby select come from a register instead of the pin
   wire          stb_eff = sw_ovr ? sw_stb : stb;

   always @* begin
      next_mode = mode;
      case (mode)
         ST_OFF:   next_mode = uv2 ? ST_OFF : ST_STBY;                 // R12
         ST_STBY:  next_mode = (!stb_eff && !uv1) ? ST_TRANS : ST_STBY; // R11 R17
         ST_TRANS: begin
            if (stb_eff || uv1)
               next_mode = ST_STBY;
            else if (trans_cnt >= stbn_lim)
               next_mode = ST_NORM;                                    // R20
         end
         ST_NORM:  next_mode = (stb_eff || uv1) ? ST_STBY : ST_NORM;   // R11 R17
         default:  next_mode = ST_STBY;
      endcase
      if (uv2)
         next_mode = ST_OFF;                                           // R12
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode      <= ST_STBY;
         trans_cnt <= {CW{1'b0}};
      end else begin
         mode      <= next_mode;
         trans_cnt <= (mode == ST_TRANS) ? inc_sat(trans_cnt) : {CW{1'b0}}; // R21
      end
   end

   // ****************************************************************
   // Transmit-dominant timeout
   // ****************************************************************
   reg [CW-1:0] tx_cnt;
   reg          tx_to;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cnt <= {CW{1'b0}};
         tx_to  <= 1'b0;
      end else if (txd) begin
         tx_cnt <= {CW{1'b0}};            // R03
         tx_to  <= 1'b0;                  // R03
      end else begin
         tx_cnt <= inc_sat(tx_cnt);       // R01 R21
         if (tx_cnt >= tx_to_lim)
            tx_to <= 1'b1;                // R02 R18
      end
   end

   // ****************************************************************
   // Standby wake filter and bus-dominant timeout
   // ****************************************************************
   reg [CW-1:0] flt_cnt;
   reg          flt_bus;
   reg [CW-1:0] bus_cnt;
   reg          bus_to;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_cnt <= {CW{1'b0}};
         flt_bus <= 1'b0;
         bus_cnt <= {CW{1'b0}};
         bus_to  <= 1'b0;
      end else begin
         // Filter follows the raw bus only after it stays changed long enough
         if (bus == flt_bus)
            flt_cnt <= {CW{1'b0}};
         else if (flt_cnt >= wake_lim) begin
            flt_bus <= bus;               // R19
            flt_cnt <= {CW{1'b0}};
         end else
            flt_cnt <= inc_sat(flt_cnt);  // R21
         if (mode == ST_NORM || !bus) begin
            bus_cnt <= {CW{1'b0}};        // R07
            bus_to  <= 1'b0;              // R07
         end else begin
            bus_cnt <= inc_sat(bus_cnt);  // R05 R21
            if (bus_cnt >= bus_to_lim)
               bus_to <= 1'b1;            // R06 R18
         end
      end
   end

   // ****************************************************************
   // Pin outputs
   // ****************************************************************
   wire norm = (mode == ST_NORM);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_dominant <= 1'b0;
         drv_enable   <= 1'b0;
         split_enable <= 1'b0;
         bus_bias_gnd <= 1'b1;
         rxd_out      <= 1'b1;
         standby      <= 1'b1;
      end else begin
         drv_enable   <= (next_mode == ST_NORM) && !ot && !tx_to;          // R02 R13 R15
         drv_dominant <= (next_mode == ST_NORM) && !ot && !tx_to && !txd; // R13 R17
         split_enable <= (next_mode == ST_NORM);
         bus_bias_gnd <= (next_mode == ST_STBY) || (next_mode == ST_TRANS);
         standby      <= (next_mode != ST_NORM);
         if (mode == ST_OFF)
            rxd_out <= 1'b1;                                // R12
         else if (norm)
            rxd_out <= !bus;                                // R14 R17
         else
            rxd_out <= bus_to ? 1'b1 : !flt_bus;            // R06 R16
      end
   end

   // ****************************************************************
   // APB slave, zero wait states
   // ****************************************************************
   localparam [31:0] CTRL_RST = `CTF_CTRL_RST;
   wire acc = psel && penable;
   wire wr  = acc && pwrite;
   reg  [31:0] rd_mux;
   reg         hit;

   always @* begin
      rd_mux = 32'h0000_0000;
      hit    = 1'b1;
      case (paddr)
         `CTF_CTRL_OFF: begin
            rd_mux[`CTF_CTRL_SW_STB] = sw_stb;
            rd_mux[`CTF_CTRL_SW_OVR] = sw_ovr;
         end
         `CTF_STATUS_OFF: begin
            rd_mux[`CTF_ST_STANDBY] = standby;
            rd_mux[`CTF_ST_TXTO]    = tx_to;
            rd_mux[`CTF_ST_BUSTO]   = bus_to;
            rd_mux[`CTF_ST_UV1]     = uv1;
            rd_mux[`CTF_ST_UV2]     = uv2;
            rd_mux[`CTF_ST_OT]      = ot;
            rd_mux[`CTF_ST_DRV_EN]  = drv_enable;
            rd_mux[`CTF_ST_RX]      = rxd_out;
            rd_mux[`CTF_ST_TRANS]   = (mode == ST_TRANS);
         end
         `CTF_TXTO_OFF:   rd_mux = zext(tx_to_lim);
         `CTF_BUSTO_OFF:  rd_mux = zext(bus_to_lim);
         `CTF_WAKEF_OFF:  rd_mux = zext(wake_lim);
         `CTF_STBN_OFF:   rd_mux = zext(stbn_lim);
         default:         hit    = 1'b0;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_stb     <= CTRL_RST[`CTF_CTRL_SW_STB];
         sw_ovr     <= CTRL_RST[`CTF_CTRL_SW_OVR];
         tx_to_lim  <= DOM_TO_CYC[CW-1:0];
         bus_to_lim <= DOM_TO_CYC[CW-1:0];
         wake_lim   <= WAKE_FLT_CYC[CW-1:0];
         stbn_lim   <= STB_NORM_CYC[CW-1:0];
         prdata     <= 32'h0000_0000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
         if (wr && pready && hit) begin
            case (paddr)
               `CTF_CTRL_OFF: begin
                  sw_stb <= pwdata[`CTF_CTRL_SW_STB];
                  sw_ovr <= pwdata[`CTF_CTRL_SW_OVR];
               end
               `CTF_TXTO_OFF:  tx_to_lim  <= pwdata[CW-1:0];
               `CTF_BUSTO_OFF: bus_to_lim <= pwdata[CW-1:0];
               `CTF_WAKEF_OFF: wake_lim   <= pwdata[CW-1:0];
               `CTF_STBN_OFF:  stbn_lim   <= pwdata[CW-1:0];
               default:        sw_ovr     <= sw_ovr;
            endcase
         end
      end
   end

endmodule // ctf_failsafe_ctrl

// ===== dv/ctf_fs_properties.sv
// Port-level assertions for the CAN fail-safe control
`timescale 1ns/1ps
module ctf_fs_props #(
   parameter DOM_TO_CYC = 50
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic txd_in,
   input wire logic txd_in_valid,
   input wire logic stb_in,
   input wire logic stb_in_valid,
   input wire logic bus_dominant,
   input wire logic uv1_flag,
   input wire logic uv2_flag,
   input wire logic ot_flag,
   input wire logic drv_dominant,
   input wire logic drv_enable,
   input wire logic split_enable,
   input wire logic bus_bias_gnd,
   input wire logic rxd_out,
   input wire logic standby
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [15:0] txl;
   // Saturates so a long low run cannot wrap back under the limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) txl <= 16'h0000;
      else if (!(txd_in_valid && !txd_in)) txl <= 16'h0000;
      else if (txl != 16'hFFFF) txl <= txl + 16'h0001;
   end
   property p_tx_to; txl > DOM_TO_CYC + 6 |-> !drv_enable; endproperty
   a_tx_to: assert property (p_tx_to) else $error("driver on after long low");
   property p_txd_float; (!txd_in_valid || txd_in) [*5] |-> !drv_dominant; endproperty
   a_txd_float: assert property (p_txd_float) else $error("dominant with txd high");
   property p_stb; (!stb_in_valid || stb_in) [*5] |-> standby; endproperty
   a_stb: assert property (p_stb) else $error("not in standby");
   property p_uv1; uv1_flag [*5] |-> standby; endproperty
   a_uv1: assert property (p_uv1) else $error("undervoltage left normal");
   property p_uv2; uv2_flag [*5] |-> !(drv_enable || split_enable || bus_bias_gnd); endproperty
   a_uv2: assert property (p_uv2) else $error("bus load while off");
   property p_ot; ot_flag [*5] |-> !drv_enable; endproperty
   a_ot: assert property (p_ot) else $error("driver on in overtemperature");
   property p_rx_ot; (ot_flag && bus_dominant && !standby) [*6] |-> !rxd_out; endproperty
   a_rx_ot: assert property (p_rx_ot) else $error("receiver stopped in overtemperature");
   property p_norm; !standby |-> split_enable && !bus_bias_gnd; endproperty
   a_norm: assert property (p_norm) else $error("normal outputs wrong");
   property p_apb; psel && !penable |=> pready; endproperty
   a_apb: assert property (p_apb) else $error("no ready after setup");
endmodule // ctf_fs_props
bind ctf_failsafe_ctrl ctf_fs_props #(.DOM_TO_CYC(DOM_TO_CYC)) ctf_fs_props_inst (.pclk,
   .presetn, .psel, .penable, .pready, .txd_in, .txd_in_valid, .stb_in, .stb_in_valid,
   .bus_dominant, .uv1_flag, .uv2_flag, .ot_flag, .drv_dominant, .drv_enable,
   .split_enable, .bus_bias_gnd, .rxd_out, .standby);

// ===== dv/ctf_ctrl_model.sv
// Behavioural CAN controller driving transmit data and standby select
`timescale 1ns/1ps
module ctf_ctrl_model (
   output logic txd_in,
   output logic txd_in_valid,
   output logic stb_in,
   output logic stb_in_valid
);
   initial begin
      txd_in = 1'b1;
      txd_in_valid = 1'b1;
      stb_in = 1'b0;
      stb_in_valid = 1'b0;
   end
   // A floating pin shows low, so only the valid flag may be trusted
   task set_txd(input logic v, input logic ok);
      txd_in <= ok ? v : 1'b0;
      txd_in_valid <= ok;
   endtask
   task set_stb(input logic v, input logic ok);
      stb_in <= ok ? v : 1'b0;
      stb_in_valid <= ok;
   endtask
endmodule // ctf_ctrl_model

// ===== dv/ctf_failsafe_ctrl_test.sv
// Self-checking testbench for the CAN fail-safe control
`timescale 1ns/1ps
`include "ctf_regs.vh"
module ctf_failsafe_ctrl_test;
   localparam DOM = 50;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic        e, txd_in, txd_in_valid, stb_in, stb_in_valid, bus_dominant = 0;
   logic        uv1_flag = 0, uv2_flag = 0, ot_flag = 0, drv_dominant, drv_enable;
   logic        split_enable, bus_bias_gnd, rxd_out, standby;
   int          n_fail = 0, compares = 0, cyc = 0;
   always #2 pclk = ~pclk;
   ctf_failsafe_ctrl #(.DOM_TO_CYC(DOM), .WAKE_FLT_CYC(4), .STB_NORM_CYC(10))
      ctf_failsafe_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txd_in(txd_in), .txd_in_valid(txd_in_valid), .stb_in(stb_in),
      .stb_in_valid(stb_in_valid), .bus_dominant(bus_dominant), .uv1_flag(uv1_flag),
      .uv2_flag(uv2_flag), .ot_flag(ot_flag), .drv_dominant(drv_dominant),
      .drv_enable(drv_enable), .split_enable(split_enable), .bus_bias_gnd(bus_bias_gnd),
      .rxd_out(rxd_out), .standby(standby));
   ctf_ctrl_model ctf_ctrl_model_inst (.txd_in(txd_in), .txd_in_valid(txd_in_valid),
      .stb_in(stb_in), .stb_in_valid(stb_in_valid));
   task stop_test();
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail = n_fail + 1;
         stop_test();
      end
   end
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      compares = compares + 1;
      if (g !== x) begin
         n_fail = n_fail + 1;
         $display("unexpected %s expected %h seen %h", s, x, g);
      end
   endtask
   // One idle cycle after each transfer keeps psel from toggling twice in a step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && cyc < 3000);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input string s);
      apb(0, a, 32'h0000_0000);
      chk(s, x, q);
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      wt(6);
      presetn <= 1;
      wt(1);
      chk("standby", 1, standby);
      chk("rxd_out", 1, rxd_out);
      rd(`CTF_TXTO_OFF, DOM, "tx limit");
      chk("read err", 0, e);
      apb(1, `CTF_BUSTO_OFF, 32'h0000_003C);
      rd(`CTF_BUSTO_OFF, 32'h0000_003C, "bus limit");
      rd(12'h020, 32'h0000_0000, "unmapped data");
      chk("unmapped err", 1, e);
      ctf_ctrl_model_inst.set_stb(0, 1);
      wt(8);
      chk("standby early", 1, standby);
      wt(12);
      chk("standby", 0, standby);
      chk("split normal", 32'h0000_0002, {split_enable, bus_bias_gnd});
      ctf_ctrl_model_inst.set_txd(0, 1);
      wt(5);
      chk("drv_dominant", 1, drv_dominant);
      chk("drv_enable", 1, drv_enable);
      wt(DOM + 10);
      chk("drv_enable timeout", 0, drv_enable);
      ctf_ctrl_model_inst.set_txd(1, 1);
      wt(5);
      chk("drv_enable back", 1, drv_enable);
      ctf_ctrl_model_inst.set_txd(0, 1);
      wt(5);
      chk("drv_dominant again", 1, drv_dominant);
      ctf_ctrl_model_inst.set_txd(1, 0);
      wt(5);
      chk("drv_dominant float", 0, drv_dominant);
      ctf_ctrl_model_inst.set_txd(0, 1);
      ot_flag <= 1;
      bus_dominant <= 1;
      wt(7);
      chk("drv_enable ot", 0, drv_enable);
      chk("rxd_out ot", 0, rxd_out);
      ot_flag <= 0;
      bus_dominant <= 0;
      ctf_ctrl_model_inst.set_txd(1, 1);
      wt(6);
      chk("drv_enable ot off", 1, drv_enable);
      uv1_flag <= 1;
      wt(6);
      chk("standby uv1", 1, standby);
      uv1_flag <= 0;
      wt(20);
      chk("standby uv1 off", 0, standby);
      apb(1, `CTF_CTRL_OFF, 32'h0000_0003);
      rd(`CTF_STATUS_OFF, 32'h0000_0081, "status override");
      apb(1, `CTF_CTRL_OFF, 32'h0000_0000);
      wt(20);
      chk("standby pin", 0, standby);
      ctf_ctrl_model_inst.set_stb(1, 1);
      wt(6);
      chk("standby sel", 1, standby);
      chk("bias standby", 32'h0000_0001, {split_enable, bus_bias_gnd});
      bus_dominant <= 1;
      wt(2);
      bus_dominant <= 0;
      wt(8);
      chk("rxd_out glitch", 1, rxd_out);
      bus_dominant <= 1;
      wt(12);
      chk("rxd_out wake", 0, rxd_out);
      wt(70);
      chk("rxd_out clamp", 1, rxd_out);
      bus_dominant <= 0;
      wt(10);
      bus_dominant <= 1;
      wt(12);
      chk("rxd_out rewake", 0, rxd_out);
      uv2_flag <= 1;
      wt(6);
      chk("zero load", 0, {drv_enable, split_enable, bus_bias_gnd});
      stop_test();
   end
endmodule // ctf_failsafe_ctrl_test
